// ===== core/uabd_regs.vh
`ifndef UABD_REGS_VH
`define UABD_REGS_VH
// ==========================================
// register byte addresses (word aligned)
`define UABD_ADDR_W 4
`define UABD_OFS_CTRL 4'h0
`define UABD_OFS_DIV_LOW 4'h4
`define UABD_OFS_DIV_HIGH 4'h8
`define UABD_OFS_RXBUF 4'hc
`define UABD_OFS_IRQ_STAT 4'h0
`define UABD_OFS_IRQ_MASK 4'h0
// ==========================================
// baud_control fields
`define UABD_CTL_START 0
`define UABD_CTL_OVF 1
`define UABD_CTL_WAKE 2
`define UABD_CTL_WIDE 3
`define UABD_CTL_HSPD 4
`define UABD_CTL_RXFLAG 5
`define UABD_CTL_RXEN 6
`define UABD_CTL_RESET 8'h00
// ==========================================
// interrupt status / mask registers
`define UABD_REG_IRQ_STAT 4'h1
`define UABD_REG_IRQ_MASK 4'h2
`define UABD_IRQ_DONE 0
`define UABD_IRQ_OVF 1
`define UABD_IRQ_WIDTH 2
// status in byte lane 1, mask in byte lane 2 of baud_control word
`define UABD_IRQ_STAT_LSB 8
`define UABD_IRQ_MASK_LSB 16
// ==========================================
// base clock dividers of the oscillator, calibration prescaler and edges to stop
`define UABD_BASE_DIV64 8'h3f
`define UABD_BASE_DIV16 8'h0f
`define UABD_BASE_DIV4 8'h03
`define UABD_CAL_PRESCALE 3'h7
`define UABD_EDGES_TO_STOP 3'h5
`endif

// ===== core/uabd_sync.v
`timescale 1ns/10ps
// ==========================================
// two flop synchroniser and rising edge detect
module uabd_sync (
   input wire sys_clk,   // clock
   input wire rst_n,     // async reset, active low
   input wire async_in,  // pin level
   output wire level,    // synchronised level
   output wire rise      // one cycle on rising edge
);
   reg meta;
   reg stable;
   reg stable_d;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b1;
         stable <= 1'b1;
         stable_d <= 1'b1;
      end else begin
         meta <= async_in;
         stable <= meta;
         stable_d <= stable;
      end
   end
   assign level = stable;
   assign rise = stable & ~stable_d;
endmodule

// ===== core/uabd_clkdiv.v
`timescale 1ns/10ps
`include "uabd_regs.vh"
// ==========================================
// base clock divider and fixed by eight prescaler
module uabd_clkdiv (
   input wire sys_clk,     // clock
   input wire rst_n,       // async reset, active low
   input wire run,         // calibration count in progress
   input wire wide_sel,    // wide_divider_select
   input wire hspd_sel,    // high_speed_select
   output reg cal_tick     // one cycle calibration clock enable
);
   reg [7:0] base_cnt;
   reg [2:0] pre_cnt;
   wire [7:0] base_top;
   wire base_tick;
   assign base_top = (wide_sel & hspd_sel) ? `UABD_BASE_DIV4 :
                     (wide_sel | hspd_sel) ? `UABD_BASE_DIV16 : `UABD_BASE_DIV64;
   assign base_tick = (base_cnt == base_top);
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_cnt <= 8'h00;
         pre_cnt <= 3'h0;
         cal_tick <= 1'b0;
      end else if (!run) begin
         base_cnt <= 8'h00;    // RULE18
         pre_cnt <= 3'h0;
         cal_tick <= 1'b0;
      end else begin
         base_cnt <= base_tick ? 8'h00 : base_cnt + 8'h01;
         cal_tick <= 1'b0;
         if (base_tick) begin
            pre_cnt <= pre_cnt + 3'h1;                      // RULE10
            cal_tick <= (pre_cnt == `UABD_CAL_PRESCALE);    // RULE11
         end
      end
   end
endmodule

// ===== core/uabd_top.v
// What this block does
// RULE1: setting start bit begins measurement
// RULE2: normal receiver held idle during calibration
// RULE3: measures 55h sync, five rising edges
// RULE4: count starts first rise after start bit
// RULE5: count stops on fifth rising edge
// RULE6: result kept, start cleared, receive flag set
// RULE7: reading receive buffer clears receive flag
// RULE8: software checks high byte zero for 8-bit
// RULE9: both divisor bytes form one 16-bit counter
// RULE10: counter clocked at one eighth base rate
// RULE11: select bits pick osc/512, /128, /32
// RULE12: final count equals bit period in base clocks
// RULE13: counter starts at one, software subtracts one
// RULE14: with wake enable, measure character after break
// RULE15: software keeps baud within measurable range
// RULE16: overflow sets flag, counting continues to edge
// RULE17: abort clears start then overflow; flag sticks
// RULE18: calibration clock by eight, gated to calibration
// RULE19: receive line synchronised, rising edges detected
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "uabd_regs.vh"
module uabd_top (
   input wire sys_clk,                    // 200 MHz clock
   input wire rst_n,                      // async reset, active low
   input wire [`UABD_ADDR_W-1:0] address, // avalon byte address
   input wire read,                       // avalon read
   input wire write,                      // avalon write
   input wire [31:0] writedata,           // avalon write data
   input wire [3:0] byteenable,           // avalon byte enables
   output reg [31:0] readdata,            // avalon read data
   output wire waitrequest,               // avalon wait
   output wire [1:0] response,            // avalon response
   input wire receive_line,               // serial input pin
   input wire [7:0] rx_data,              // byte from normal receiver
   input wire rx_data_valid,              // normal receiver byte done
   output wire rx_enable,                 // normal receiver may run
   output wire irq                        // level interrupt
);
   // ==========================================
   // state
   localparam ST_IDLE = 2'h0;
   localparam ST_BREAK = 2'h1;
   localparam ST_START = 2'h2;
   localparam ST_COUNT = 2'h3;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [15:0] rate_divisor;
   reg [7:0] receive_buffer;
   reg start_bit;
   reg overflow_bit;
   reg wake_bit;
   reg wide_sel;
   reg hspd_sel;
   reg rx_en_bit;
   reg receive_flag;
   reg [2:0] edge_cnt;
   reg [`UABD_IRQ_WIDTH-1:0] irq_stat;
   reg [`UABD_IRQ_WIDTH-1:0] irq_mask;
   reg ack;
   reg err;

   wire rx_level;
   wire rx_rise;
   wire cal_tick;
   wire run;
   wire done;
   wire ovf_evt;
   wire acc;
   wire wr_ok;
   wire rd_ok;
   wire [7:0] ctrl_val;

   // ==========================================
   // decoding used by read and write paths
   function is_reg;
      input [`UABD_ADDR_W-1:0] a;
      input [3:0] ofs;
      begin
         is_reg = (a == ofs);
      end
   endfunction

   function mapped;
      input [`UABD_ADDR_W-1:0] a;
      begin
         mapped = (a[1:0] == 2'b00);
      end
   endfunction

   // ==========================================
   // receive line
   uabd_sync u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(receive_line),
      .level(rx_level),
      .rise(rx_rise)          // RULE19
   );

   assign run = (state == ST_COUNT);

   uabd_clkdiv u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(run),              // RULE18
      .wide_sel(wide_sel),
      .hspd_sel(hspd_sel),
      .cal_tick(cal_tick)
   );

   // ==========================================
   // measurement sequence
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_bit)
               next_state = wake_bit ? ST_BREAK : ST_START;  // RULE1 RULE14
         end
         ST_BREAK: begin
            if (!start_bit)
               next_state = ST_IDLE;
            else if (rx_rise)
               next_state = ST_START;   // RULE14
         end
         ST_START: begin
            if (!start_bit)
               next_state = ST_IDLE;
            else if (rx_rise)
               next_state = ST_COUNT;   // RULE4
         end
         ST_COUNT: begin
            if (!start_bit)
               next_state = ST_IDLE;
            else if (done)
               next_state = ST_IDLE;    // RULE5
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // fifth rise ends count; first rise starts it
   assign done = (state == ST_COUNT) && rx_rise && (edge_cnt == `UABD_EDGES_TO_STOP - 3'h1);  // RULE3 RULE5
   assign ovf_evt = (state == ST_COUNT) && cal_tick && (rate_divisor == 16'hffff);           // RULE16

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         edge_cnt <= 3'h0;
      end else begin
         state <= next_state;
         if (state == ST_START && rx_rise)
            edge_cnt <= 3'h1;
         else if (state == ST_COUNT && rx_rise)
            edge_cnt <= edge_cnt + 3'h1;
      end
   end

   assign rx_enable = rx_en_bit && (state == ST_IDLE) && !start_bit;  // RULE2

   // ==========================================
   // avalon slave: one wait cycle, then ack
   assign acc = (read | write) & ~ack;
   assign waitrequest = (read | write) & ~ack;
   assign response = err ? 2'b11 : 2'b00;
   assign wr_ok = write & ack & mapped(address);
   assign rd_ok = read & ack & mapped(address);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         err <= 1'b0;
      end else begin
         ack <= acc;
         err <= acc & ~mapped(address);
      end
   end

   assign ctrl_val = {1'b0, rx_en_bit, receive_flag, hspd_sel, wide_sel, wake_bit, overflow_bit, start_bit};

   // ==========================================
   // control, divisor and flags
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_bit <= 1'b0;
         overflow_bit <= 1'b0;
         wake_bit <= 1'b0;
         wide_sel <= 1'b0;
         hspd_sel <= 1'b0;
         rx_en_bit <= 1'b0;
         receive_flag <= 1'b0;
         rate_divisor <= 16'h0000;
         receive_buffer <= 8'h00;
         irq_stat <= {`UABD_IRQ_WIDTH{1'b0}};
         irq_mask <= {`UABD_IRQ_WIDTH{1'b0}};
      end else begin
         // software writes
         if (wr_ok && byteenable[0]) begin
            if (is_reg(address, `UABD_OFS_CTRL)) begin
               start_bit <= writedata[`UABD_CTL_START];
               wake_bit <= writedata[`UABD_CTL_WAKE];
               wide_sel <= writedata[`UABD_CTL_WIDE];
               hspd_sel <= writedata[`UABD_CTL_HSPD];
               rx_en_bit <= writedata[`UABD_CTL_RXEN];
               // overflow may be cleared only once start is low
               if (!writedata[`UABD_CTL_OVF] && !start_bit)
                  overflow_bit <= 1'b0;  // RULE17
            end
            if (is_reg(address, `UABD_OFS_DIV_LOW))
               rate_divisor[7:0] <= writedata[7:0];
            if (is_reg(address, `UABD_OFS_DIV_HIGH))
               rate_divisor[15:8] <= writedata[7:0];
         end
         // status and mask share the control word, lanes 1 and 2
         if (wr_ok && byteenable[1] && is_reg(address, `UABD_OFS_IRQ_STAT))
            irq_stat <= irq_stat & ~writedata[`UABD_IRQ_STAT_LSB +: `UABD_IRQ_WIDTH];
         if (wr_ok && byteenable[2] && is_reg(address, `UABD_OFS_IRQ_MASK))
            irq_mask <= writedata[`UABD_IRQ_MASK_LSB +: `UABD_IRQ_WIDTH];
         // reading the buffer clears the flag
         if (rd_ok && is_reg(address, `UABD_OFS_RXBUF))
            receive_flag <= 1'b0;  // RULE7
         // normal receiver bytes
         if (rx_data_valid && rx_enable) begin
            receive_buffer <= rx_data;
            receive_flag <= 1'b1;
         end
         // measurement: counter starts at one
         if (state == ST_START && rx_rise)
            rate_divisor <= 16'h0001;  // RULE13 RULE9
         else if (state == ST_COUNT && cal_tick)
            rate_divisor <= rate_divisor + 16'h0001;  // RULE9 RULE12
         if (ovf_evt) begin
            overflow_bit <= 1'b1;  // RULE16
            irq_stat[`UABD_IRQ_OVF] <= 1'b1;
         end
         if (done) begin
            start_bit <= 1'b0;      // RULE6
            receive_flag <= 1'b1;   // RULE6
            irq_stat[`UABD_IRQ_DONE] <= 1'b1;
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ==========================================
   // read data
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (acc && read) begin
         readdata <= 32'h0000_0000;
         if (is_reg(address, `UABD_OFS_CTRL))
            readdata <= {8'h00, 6'h00, irq_mask, 6'h00, irq_stat, ctrl_val};
         else if (is_reg(address, `UABD_OFS_DIV_LOW))
            readdata <= {24'h000000, rate_divisor[7:0]};
         else if (is_reg(address, `UABD_OFS_DIV_HIGH))
            readdata <= {24'h000000, rate_divisor[15:8]};  // RULE8
         else if (is_reg(address, `UABD_OFS_RXBUF))
            readdata <= {24'h000000, receive_buffer};
      end
   end
endmodule

// ===== tb/uabd_checker_asserts.sv
`timescale 1ns/10ps
`include "uabd_regs.vh"
// ==========================================
// port checker
module uabd_checker (
   input wire sys_clk,                    // clock
   input wire rst_n,                      // reset, active low
   input wire [`UABD_ADDR_W-1:0] address, // byte address
   input wire read,                       // read
   input wire write,                      // write
   input wire [31:0] writedata,           // write data
   input wire [3:0] byteenable,           // lanes
   input wire [31:0] readdata,            // read data
   input wire waitrequest,                // wait
   input wire [1:0] response,             // response
   input wire receive_line,               // serial pin
   input wire rx_enable,                  // receiver may run
   input wire irq                         // interrupt
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_go;
      write && !waitrequest && address == 4'h0 && byteenable[0] && writedata[0];
   endsequence
   sequence s_off4;
      (!rx_enable)[*4];
   endsequence
   a_wait_first: assert property ((read || write) && !$past(read || write) |-> waitrequest)
      else $error("new request without wait");
   a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait longer than one cycle");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("wait without request");
   a_resp_bad: assert property ((read || write) && !waitrequest && address[1:0] != 2'h0 |-> response == 2'h3)
      else $error("unmapped access not refused");
   a_resp_good: assert property ((read || write) && !waitrequest && address[1:0] == 2'h0 |-> response == 2'h0)
      else $error("mapped access refused");
   a_rx_held: assert property (s_go |=> s_off4)
      else $error("receiver not held idle");
   a_rdata_stands: assert property ($changed(readdata) |-> $past(read))
      else $error("read data moved without read");
   a_irq_cause: assert property ($rose(irq) |-> receive_line || $past(write) || $past(write, 2))
      else $error("interrupt without cause");
endmodule
bind uabd_top uabd_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .response(response), .receive_line(receive_line),
   .rx_enable(rx_enable), .irq(irq));

// ===== tb/uabd_tx_model.sv
`timescale 1ns/10ps
// ==========================================
// remote sender of the sync character
module uabd_tx_model (
   input wire sys_clk,       // clock
   input wire go,            // send one frame
   input wire brk,           // lead with a break
   input wire [15:0] period, // bit time in clocks
   output reg line,          // serial line, idles high
   output reg busy           // frame in flight
);
   reg [9:0] fr;
   integer i;
   initial begin
      line = 1'b1;
      busy = 1'b0;
      fr = {1'b1, 8'h55, 1'b0};
      forever begin
         @(posedge sys_clk);
         if (go) begin
            busy <= 1'b1;
            if (brk) begin
               line <= 1'b0;
               repeat (13 * period) @(posedge sys_clk);
               line <= 1'b1;
               repeat (2 * period) @(posedge sys_clk);
            end
            for (i = 0; i < 10; i = i + 1) begin
               line <= fr[i];
               repeat (period) @(posedge sys_clk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// ===== tb/uart_auto_baud_detect_bench.sv
`timescale 1ns/10ps
module uart_auto_baud_detect_bench;
   reg sys_clk, rst_n, read, write, go, brk;
   reg [3:0] address, lanes;
   reg [31:0] writedata, rd, lo;
   reg [15:0] pc;
   reg [1:0] rsp;
   wire [31:0] readdata;
   wire [1:0] response;
   wire waitrequest, rx_enable, irq, line, busy;
   integer miscompares = 0;
   integer n_checks = 0;
   integer m;
   uabd_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(lanes), .readdata(readdata), .waitrequest(waitrequest),
      .response(response), .receive_line(line), .rx_data(8'h00), .rx_data_valid(1'b0),
      .rx_enable(rx_enable), .irq(irq));
   uabd_tx_model far (.sys_clk(sys_clk), .go(go), .brk(brk), .period(pc), .line(line), .busy(busy));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // ==========================================
   // bus access, held until wait drops
   task acc(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         address <= a;
         writedata <= d;
         read <= !w;
         write <= w;
         @(posedge sys_clk);
         while (waitrequest !== 1'b0) @(posedge sys_clk);
         rd = readdata;
         rsp = response;
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   // ==========================================
   // one calibration, result within one count
   task cal(input [7:0] c, input b, input [15:0] p, input [15:0] e);
      begin
         acc(1'b1, 4'h0, {24'h0, c | 8'h41});
         @(negedge sys_clk);
         chk("rxen", 0, rx_enable);
         @(posedge sys_clk);
         brk <= b;
         pc <= p;
         go <= 1'b1;
         @(posedge sys_clk);
         go <= 1'b0;
         @(posedge sys_clk);
         while (busy !== 1'b0) @(posedge sys_clk);
         repeat (4) @(posedge sys_clk);
         acc(1'b0, 4'h0, 0);
         chk("ctl", 8'h60, rd & 8'h63);
         acc(1'b0, 4'h4, 0);
         lo = rd;
         acc(1'b0, 4'h8, 0);
         chk("dhigh", 0, rd[7:0]);
         chk("div", 1, {31'h0, {rd[7:0], lo[7:0]} >= e - 1 && {rd[7:0], lo[7:0]} <= e + 1});
         acc(1'b0, 4'hc, 0);
         acc(1'b0, 4'h0, 0);
         chk("flag", 0, rd[5]);
         chk("rxback", 1, rx_enable);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d miscompares %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      miscompares = miscompares + 1;
      give_verdict;
   end
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      go = 1'b0;
      brk = 1'b0;
      pc = 16'h0040;
      lanes = 4'h1;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      acc(1'b0, 4'h0, 0);
      chk("ctlrst", 0, rd);
      acc(1'b0, 4'h1, 0);
      chk("resp", 2'h3, rsp);
      $display("test reset done");
      acc(1'b1, 4'h0, 32'h41);
      acc(1'b1, 4'h0, 32'h40);
      acc(1'b0, 4'h0, 0);
      chk("abort", 32'h40, rd);
      $display("test abort done");
      for (m = 0; m < 4; m = m + 1) begin
         cal(m << 3, 1'b0, (m == 0) ? 256 : (m == 3) ? 64 : 128, (m == 0) ? 5 : (m == 3) ? 17 : 9);
         $display("test mode %0d done", m);
      end
      cal(8'h1c, 1'b1, 64, 17);
      $display("test break done");
      chk("irqoff", 0, irq);
      lanes <= 4'h7;
      acc(1'b1, 4'h0, 32'h0001_0340);
      lanes <= 4'h1;
      @(negedge sys_clk);
      chk("irqclr", 0, irq);
      cal(8'h18, 1'b0, 64, 17);
      chk("irqon", 1, irq);
      lanes <= 4'h7;
      acc(1'b1, 4'h0, 32'h0001_0340);
      lanes <= 4'h1;
      @(negedge sys_clk);
      chk("irqack", 0, irq);
      $display("test irq done");
      give_verdict;
   end
endmodule
